// File: rtl/fms_pkg.sv
// constants and types for the failsafe and millisecond timers
// Notes on behaviour
// (RQ1) The failsafe count restarts at the start of every machine cycle.
// (RQ2) The failsafe timer expires after about 10 ms without an acknowledge.
// (RQ3) On expiry the failsafe timer drives its own acknowledge to the cpu.
// (RQ4) A disable input turns the failsafe off so cycles wait indefinitely.
// (RQ5) The ms timer runs on its own, apart from baud clock and failsafe.
// (RQ6) With slow select on, the ms output is low 0.7 ms in a 1.4 ms period.
// (RQ7) With slow select off, the ms output is low 1.0 ms in a 2.0 ms period.
// (RQ8) The ms timer reset input may be asserted at any moment.
// (RQ9) Without reset the ms timer free-runs as a symmetrical square wave.
// (RQ10) A real acknowledge cancels the timeout; own ack ends with the cycle.
// (RQ11) On reset release the ms timer starts again with its low phase.
package fms_pkg;
  localparam int CLK_MHZ          = 100;
  localparam int FAILSAFE_TIME_US = 10000;
  localparam int HALF_SLOW_US     = 700;
  localparam int HALF_NORM_US     = 1000;
  localparam int FAILSAFE_CYCLES  = FAILSAFE_TIME_US * CLK_MHZ;
  localparam int HALF_SLOW_CYCLES = HALF_SLOW_US * CLK_MHZ;
  localparam int HALF_NORM_CYCLES = HALF_NORM_US * CLK_MHZ;
  localparam int SYNC_BITS        = 5;
  localparam int SYNC_CYC         = 0;
  localparam int SYNC_ACK         = 1;
  localparam int SYNC_EN          = 2;
  localparam int SYNC_SLOW        = 3;
  localparam int SYNC_MSRST       = 4;

  typedef enum logic [1:0] {
    FMS_IDLE  = 2'b00,
    FMS_WAIT  = 2'b01,
    FMS_OWN   = 2'b11,
    FMS_DONE  = 2'b10
  } fms_state_t;
endpackage : fms_pkg

// File: rtl/fms_ms_if.sv
// link between failsafe top and millisecond timer
`timescale 1ns/1ps
interface fms_ms_if;
  logic slow_sel;
  logic timer_reset;
  logic ms_out;
  modport ctl (output slow_sel, output timer_reset, input ms_out);
  modport tmr (input slow_sel, input timer_reset, output ms_out);
endinterface : fms_ms_if

// File: rtl/fms_ms_timer.sv
// free-running millisecond square-wave timer
`timescale 1ns/1ps
module fms_ms_timer #(
  parameter int HALF_SLOW = fms_pkg::HALF_SLOW_CYCLES,
  parameter int HALF_NORM = fms_pkg::HALF_NORM_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  fms_ms_if.tmr     mif
);
  localparam int CW = $clog2(HALF_NORM + 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          out_reg;
  logic          out_next;
  logic [CW-1:0] half_m1;

  // slow select is read live; turning it on mid-phase ends the phase early, turning it off stretches the phase
  assign half_m1 = mif.slow_sel ? CW'(HALF_SLOW - 1) : CW'(HALF_NORM - 1);

  // no input from the failsafe side reaches this counter [RQ5]
  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    out_next = out_reg;
    if (mif.timer_reset) begin
      cnt_next = '0; // [RQ8]
      out_next = 1'b0; // [RQ11]
    end else if (cnt_reg >= half_m1) begin
      cnt_next = '0;
      out_next = ~out_reg; // [RQ6] [RQ7] [RQ9]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign mif.ms_out = out_reg;

  a_reset_holds: assert property ( // [RQ8]
    @(posedge clk) disable iff (!rst_n)
    mif.timer_reset |=> (cnt_reg == '0 && !out_reg))
    else $error("ms timer not held by its reset");

  a_low_after_reset: assert property ( // [RQ11]
    @(posedge clk) disable iff (!rst_n)
    $fell(mif.timer_reset) |-> (!out_reg ##1 !out_reg))
    else $error("ms timer did not restart low");

  a_half_period: assert property ( // [RQ6] [RQ7] [RQ9]
    @(posedge clk) disable iff (!rst_n)
    ($changed(out_reg) && !$past(mif.timer_reset))
      |-> ($past(cnt_reg) >= $past(half_m1)))
    else $error("ms timer toggled early");

  a_toggle_due: assert property ( // [RQ9]
    @(posedge clk) disable iff (!rst_n)
    (!mif.timer_reset && cnt_reg >= half_m1) |=> $changed(out_reg))
    else $error("ms timer missed its toggle");
endmodule : fms_ms_timer

// File: rtl/fms_top.sv
// bus-cycle failsafe timer with millisecond reference timer
`timescale 1ns/1ps
module fms_top #(
  parameter int FAILSAFE_CNT = fms_pkg::FAILSAFE_CYCLES,
  parameter int HALF_SLOW    = fms_pkg::HALF_SLOW_CYCLES,
  parameter int HALF_NORM    = fms_pkg::HALF_NORM_CYCLES
) (
  input  wire logic MCLK,
  input  wire logic RST_N,
  input  wire logic CYCLE_ACTIVE,
  input  wire logic XFER_ACK_IN,
  input  wire logic FAILSAFE_EN,
  input  wire logic SLOW_SEL,
  input  wire logic MS_TIMER_RESET_IN,
  output wire logic FAILSAFE_ACK,
  output wire logic MS_TIMER_OUT
);
  localparam int FW = $clog2(FAILSAFE_CNT + 1);
  localparam logic [FW-1:0] LIM_M1 = FW'(FAILSAFE_CNT - 1);

  logic                           rst_meta_reg;
  logic                           rst_n_sync;
  logic [fms_pkg::SYNC_BITS-1:0]  meta_reg;
  logic [fms_pkg::SYNC_BITS-1:0]  sync_reg;
  logic                           cyc_d_reg;
  logic                           cyc_s;
  logic                           ack_s;
  logic                           en_s;
  logic                           start;
  fms_pkg::fms_state_t            state_reg;
  fms_pkg::fms_state_t            state_next;
  logic [FW-1:0]                  cnt_reg;
  logic [FW-1:0]                  cnt_next;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // every pin input except MCLK and RST_N crosses two flops before any logic sees it
  genvar gi;
  generate
    for (gi = 0; gi < fms_pkg::SYNC_BITS; gi++) begin : g_sync
      logic pin;
      always_comb begin
        case (gi)
          fms_pkg::SYNC_CYC:   pin = CYCLE_ACTIVE;
          fms_pkg::SYNC_ACK:   pin = XFER_ACK_IN;
          fms_pkg::SYNC_EN:    pin = FAILSAFE_EN;
          fms_pkg::SYNC_SLOW:  pin = SLOW_SEL;
          default:             pin = MS_TIMER_RESET_IN;
        endcase
      end
      always_ff @(posedge MCLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= pin;
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  assign cyc_s = sync_reg[fms_pkg::SYNC_CYC];
  assign ack_s = sync_reg[fms_pkg::SYNC_ACK];
  assign en_s  = sync_reg[fms_pkg::SYNC_EN];
  assign start = cyc_s & ~cyc_d_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!en_s) begin
      state_next = fms_pkg::FMS_IDLE; // [RQ4]
      cnt_next   = '0;
    end else if (start) begin
      state_next = fms_pkg::FMS_WAIT; // [RQ1]
      cnt_next   = '0;
    end else begin
      case (state_reg)
        fms_pkg::FMS_WAIT: begin
          if (!cyc_s) begin
            state_next = fms_pkg::FMS_IDLE;
          end else if (ack_s) begin
            state_next = fms_pkg::FMS_DONE; // [RQ10]
          end else if (cnt_reg == LIM_M1) begin
            state_next = fms_pkg::FMS_OWN; // [RQ2]
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        fms_pkg::FMS_OWN, fms_pkg::FMS_DONE: begin
          if (!cyc_s) begin
            state_next = fms_pkg::FMS_IDLE; // [RQ10]
          end
        end
        default: state_next = fms_pkg::FMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= fms_pkg::FMS_IDLE;
      cnt_reg   <= '0;
      cyc_d_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      cyc_d_reg <= cyc_s;
    end
  end

  // acknowledge held from expiry until the cycle closes
  assign FAILSAFE_ACK = (state_reg == fms_pkg::FMS_OWN); // [RQ3]

  fms_ms_if mif ();
  assign mif.slow_sel    = sync_reg[fms_pkg::SYNC_SLOW];
  assign mif.timer_reset = sync_reg[fms_pkg::SYNC_MSRST]; // [RQ8]
  assign MS_TIMER_OUT    = mif.ms_out;

  fms_ms_timer #(
    .HALF_SLOW (HALF_SLOW),
    .HALF_NORM (HALF_NORM)
  ) u_ms (
    .clk   (MCLK),
    .rst_n (rst_n_sync),
    .mif   (mif)
  );

  sequence s_expire;
    en_s && !start && cyc_s && !ack_s
      && state_reg == fms_pkg::FMS_WAIT && cnt_reg == LIM_M1;
  endsequence

  sequence s_own_ack;
    FAILSAFE_ACK;
  endsequence

  a_ack_on_expiry: assert property ( // [RQ2] [RQ3]
    @(posedge MCLK) disable iff (!rst_n_sync)
    s_expire |=> s_own_ack)
    else $error("no own acknowledge at expiry");

  a_no_early_ack: assert property ( // [RQ2]
    @(posedge MCLK) disable iff (!rst_n_sync)
    $rose(FAILSAFE_ACK) |-> ($past(cnt_reg) == LIM_M1))
    else $error("own acknowledge before timeout");

  a_restart_start: assert property ( // [RQ1]
    @(posedge MCLK) disable iff (!rst_n_sync)
    (start && en_s) |=> (cnt_reg == '0 && state_reg == fms_pkg::FMS_WAIT))
    else $error("failsafe did not restart on new cycle");

  a_disable_idle: assert property ( // [RQ4]
    @(posedge MCLK) disable iff (!rst_n_sync)
    !en_s |=> (!FAILSAFE_ACK && cnt_reg == '0))
    else $error("failsafe active while disabled");

  a_real_ack_cancel: assert property ( // [RQ10]
    @(posedge MCLK) disable iff (!rst_n_sync)
    (en_s && !start && cyc_s && ack_s && state_reg == fms_pkg::FMS_WAIT)
      |=> (state_reg == fms_pkg::FMS_DONE) ##1 !$rose(FAILSAFE_ACK))
    else $error("real acknowledge did not cancel timeout");

  a_own_ack_ends: assert property ( // [RQ10]
    @(posedge MCLK) disable iff (!rst_n_sync)
    (FAILSAFE_ACK && !cyc_s && !start) |=> !FAILSAFE_ACK)
    else $error("own acknowledge outlived the cycle");
endmodule : fms_top

// File: sim/fms_cpu_model.sv
// processor bus-cycle model facing the failsafe timer
`timescale 1ns/1ps
module fms_cpu_model (
  input  wire logic clk,
  input  wire logic fs_ack,
  output logic      cyc,
  output logic      xack,
  output logic      done,
  output logic      own,
  output int        lat
);
  initial begin
    cyc = 1'b0;
    xack = 1'b0;
    done = 1'b0;
    own = 1'b0;
    lat = 0;
  end

  // ends on the own acknowledge, or gives up after limit cycles
  // a real acknowledge is held to the end of the cycle, so a missed
  // cancellation still shows up as an own acknowledge
  task automatic bus_cycle(input int ack_at, input int limit);
    own = 1'b0;
    lat = 0;
    cyc = 1'b1;
    while (lat < limit && own !== 1'b1) begin
      @(posedge clk);
      #1;
      lat++;
      own = fs_ack;
      if (lat == ack_at) xack = 1'b1;
    end
    cyc = 1'b0;
    xack = 1'b0;
    done = 1'b1;
    @(posedge clk);
    #1 done = 1'b0;
    // one idle cycle so the next start is seen as a fresh rise
    @(posedge clk);
    #1;
  endtask : bus_cycle
endmodule : fms_cpu_model

// File: sim/failsafe_and_ms_timer_tb_top.sv
// self-checking bench for the failsafe and millisecond timers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module failsafe_and_ms_timer_tb_top;
  localparam int FCNT = 20;
  localparam int HS   = 7;
  localparam int HN   = 10;
  typedef struct {logic v; int n; int tol;} fms_exp_t;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       en = 1'b1;
  logic       slow = 1'b0;
  logic       msr = 1'b0;
  logic       cyc, xack, fs_ack, ms_out, c_done, c_own, ms_prev;
  int         c_lat, run, n_errors, cmp_count;
  int         seed = 32'h283f;
  fms_exp_t   q_fs[$];
  fms_exp_t   q_ms[$];
  fms_exp_t   e;

  always #5 mclk = ~mclk;

  fms_top #(.FAILSAFE_CNT(FCNT), .HALF_SLOW(HS), .HALF_NORM(HN)) dut (
    .MCLK(mclk), .RST_N(rst_n), .CYCLE_ACTIVE(cyc), .XFER_ACK_IN(xack),
    .FAILSAFE_EN(en), .SLOW_SEL(slow), .MS_TIMER_RESET_IN(msr),
    .FAILSAFE_ACK(fs_ack), .MS_TIMER_OUT(ms_out));
  fms_cpu_model cpu (.clk(mclk), .fs_ack(fs_ack), .cyc(cyc), .xack(xack),
    .done(c_done), .own(c_own), .lat(c_lat));

  // sync latency blurs edges by a cycle or two, hence the tolerance
  function automatic int near(input int g, input fms_exp_t x);
    return (g >= x.n - x.tol && g <= x.n + x.tol) ? x.n : g;
  endfunction : near

  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(negedge mclk) begin
    if (c_done && q_fs.size() > 0) begin
      e = q_fs.pop_front();
      `CHK(c_own, e.v)
      `CHK(near(c_lat, e), e.n)
    end
    if (msr) run = 0;
    else if (ms_out !== ms_prev) begin
      if (q_ms.size() > 0) begin
        e = q_ms.pop_front();
        `CHK(ms_prev, e.v)
        `CHK(near(run, e), e.n)
      end
      run = 1;
    end else run++;
    ms_prev = ms_out;
  end

  task fs_test;
    int a;
    repeat (2) begin
      q_fs.push_back('{1'b1, FCNT + 3, 1});
      cpu.bus_cycle(0, 4 * FCNT);
    end
    repeat (4) @(posedge mclk);
    #1 `CHK(fs_ack, 1'b0)
    a = 2 + ($unsigned($random(seed)) % 10);
    q_fs.push_back('{1'b0, 4 * FCNT, 0});
    cpu.bus_cycle(a, 4 * FCNT);
    en = 1'b0;
    repeat (4) @(posedge mclk);
    #1 q_fs.push_back('{1'b0, 3 * FCNT, 0});
    cpu.bus_cycle(0, 3 * FCNT);
    en = 1'b1;
    $display("test failsafe done");
  endtask : fs_test

  task ms_test;
    int h;
    for (int s = 1; s >= 0; s--) begin
      h = s ? HS : HN;
      repeat (1 + $unsigned($random(seed)) % 9) @(posedge mclk);
      #1 slow = s[0];
      msr = 1'b1;
      repeat (6) @(posedge mclk);
      #1 msr = 1'b0;
      q_ms.push_back('{1'b0, h + 2, 2});
      q_ms.push_back('{1'b1, h, 0});
      q_ms.push_back('{1'b0, h, 0});
      q_ms.push_back('{1'b1, h, 0});
      for (int i = 0; i < 10 * h && q_ms.size() > 0; i++) @(posedge mclk);
      if (q_ms.size() > 0) begin
        n_errors++;
        q_ms.delete();
      end
      $display("test ms timer slow=%0d done", s);
    end
  endtask : ms_test

  initial begin
    repeat (10) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    fork
      fs_test();
      ms_test();
    join
    repeat (4) @(posedge mclk);
    if (q_fs.size() > 0) n_errors++;
    give_verdict();
  end
endmodule : failsafe_and_ms_timer_tb_top
